// File: logic/hces_map.vh
`ifndef HCES_MAP_VH
`define HCES_MAP_VH
// register byte addresses (index times four)
`define HCES_IDX_STAT_B      8'h3B
`define HCES_ADDR_STAT_B     10'h0EC
`define HCES_ADDR_STAT_A     10'h0E8
`define HCES_ADDR_CTRL       10'h0F0
`define HCES_ADDR_STATE      10'h0F4
`define HCES_ADDR_LINE       10'h0F8
`define HCES_ADDR_RXINFO     10'h0FC
// control register fields
`define HCES_CTL_AUTO        0
`define HCES_CTL_LOOP        1
`define HCES_CTL_DMA         2
`define HCES_CTL_DPLL_RX     3
`define HCES_CTL_DPLL_TX     4
`define HCES_CTL_VIS         5
`define HCES_CTL_W           6
// event mask: bits set mean masked
`define HCES_MASK_RST        8'hFF
`define HCES_STAT_RST        8'h00
// status a bit positions
`define HCES_A_RFS           6
`define HCES_A_RSC           5
`define HCES_A_PCE           4
`define HCES_A_DPLL_UNSYNC_FLAG          3
`define HCES_A_CARRIER_CHANGE_FLAG          2
`define HCES_A_RFO           1
`define HCES_A_RPF           0
// status b bit positions
`define HCES_B_EOP           7
`define HCES_B_OLP           6
`define HCES_B_ACTIVE_ON_LOOP_FLAG          5
`define HCES_B_XPR           0
// loop states, frame-start byte delay and pool size
`define HCES_LS_OFF          2'h0
`define HCES_LS_WAIT_ON      2'h1
`define HCES_LS_ON           2'h2
`define HCES_LS_ACTIVE       2'h3
`define HCES_LS_WAIT_ACT     2'h1
`define HCES_FRAME_DELAY     2'h2
`define HCES_POOL_BYTES      6'h20
`endif

// File: logic/hces_top.v
// Functional notes
// - raise frame-start flag two bytes after address match or opening flag.
// - control field, address low, status bits 3..0 valid when frame-start rises.
// - auto mode: remote ready change sets flag; present state readable.
// - auto mode: bad N(R) or S-frame with info field sets protocol error.
// - DPLL lock loss sets unsync flag when receive clock uses DPLL.
// - while DPLL unsynced, receiver aborted and disabled until lock returns.
// - DPLL unsync also halts transmit when transmit clock uses DPLL.
// - every carrier detect edge sets flag; level readable separately.
// - discarded complete frame due to full FIFO sets frame overflow flag.
// - 32 bytes of unfinished frame in FIFO set pool full flag.
// - pool full event only in interrupt mode, never DMA mode.
// - reading second status register clears only the bits it returned.
// - transmit pool ready bit also cleared on its vector output.
// - masked-visible option records masked events; no vector or summary.
// - loop mode: end-of-poll sequence sets end-of-poll flag.
// - go-on-loop sets on-loop at next end-of-poll; also on leaving active.
// - on-loop: received bits repeated onto transmit with one bit delay.
// - outside loop mode data overflow flag warns; reception continues later.
// - data overflow event belongs to interrupt group 7 or 8.
// - data overflow event raised at once, independent of frame status byte.
// - go-active-on-loop sets active-on-loop flag at next end-of-poll.
// - entering active-on-loop stops repeating and starts own transmission.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`include "hces_map.vh"
module hces_top
(
  // clock and reset
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  // avalon-mm slave
  input  wire [9:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output reg  [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  // receiver events
  input  wire        FRAME_START_I,
  input  wire        RX_BYTE_I,
  input  wire [7:0]  RX_CONTROL_FIELD_I,
  input  wire [7:0]  RX_ADDRESS_LOW_I,
  input  wire [3:0]  RX_STATUS_LOW_I,
  input  wire        REMOTE_READY_I,
  input  wire        REMOTE_READY_VALID_I,
  input  wire        BAD_NR_I,
  input  wire        SFRAME_INFO_I,
  input  wire        DPLL_LOCK_I,
  input  wire        CARRIER_DETECT_I,
  input  wire        FRAME_DISCARD_I,
  input  wire [5:0]  FRAME_FILL_I,
  input  wire        FRAME_END_I,
  input  wire        FIFO_OVERRUN_I,
  input  wire        END_OF_POLL_I,
  // transmit side events
  input  wire        TX_POOL_READY_I,
  input  wire        TX_POOL_VECTOR_I,
  input  wire        GO_ON_LOOP_I,
  input  wire        GO_ACTIVE_I,
  input  wire        LEAVE_ACTIVE_I,
  // serial line
  input  wire        BIT_STROBE_I,
  input  wire        RXD_I,
  input  wire        OWN_TXD_I,
  output reg         TXD_O,
  // receiver and transmitter control
  output wire        RX_ABORT_O,
  output wire        TX_HALT_O,
  output wire        OWN_TX_EN_O,
  // summary and vector request
  output wire [1:0]  EVENT_SUMMARY_O,
  output wire        INT_GROUP8_O
);

  ////////////////////////////////////////////////////////////////////////////
  reg  [1:0]  rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  reg  [`HCES_CTL_W-1:0] ctrl_q;
  reg  [7:0]  mask_a_q;
  reg  [7:0]  mask_b_q;
  reg  [7:0]  stat_a_q;
  reg  [7:0]  stat_b_q;
  reg  [1:0]  loop_q;
  reg         pend_act_q;
  reg  [1:0]  fs_cnt_q;
  reg         fs_run_q;
  reg  [7:0]  ctl_field_q;
  reg  [7:0]  addr_low_q;
  reg  [3:0]  stat_low_q;
  reg         remote_ready_q;
  reg         dpll_lock_q;
  reg         cd_q;
  reg         fill_hit_q;
  reg         rd_done_q;

  wire auto_mode = ctrl_q[`HCES_CTL_AUTO];
  wire loop_mode = ctrl_q[`HCES_CTL_LOOP];
  wire dma_mode  = ctrl_q[`HCES_CTL_DMA];
  wire dpll_rx   = ctrl_q[`HCES_CTL_DPLL_RX];
  wire dpll_tx   = ctrl_q[`HCES_CTL_DPLL_TX];
  wire masked_visible_option       = ctrl_q[`HCES_CTL_VIS];

  // single-cycle wait state so read data leaves a flop
  wire req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~rd_done_q;
  wire acc    = req & rd_done_q;
  wire rd_acc = acc & AVS_READ_I;
  wire wr_acc = acc & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
  wire rd_a   = rd_acc & (AVS_ADDRESS_I == `HCES_ADDR_STAT_A);
  wire rd_b   = rd_acc & (AVS_ADDRESS_I == `HCES_ADDR_STAT_B);
  // read data is loaded in the wait cycle so it stands at the accepting edge
  wire rd_first = req & ~rd_done_q & AVS_READ_I;
  // a read clears only what it showed; events after the load stay pending
  wire [7:0] clr_a = rd_a ? AVS_READDATA_O[7:0] : 8'h00;
  wire [7:0] clr_b = (rd_b ? AVS_READDATA_O[7:0] : 8'h00) | {7'h0, TX_POOL_VECTOR_I};

  ////////////////////////////////////////////////////////////////////////////
  // event detection
  wire dpll_unsync = dpll_rx & ~DPLL_LOCK_I;
  wire fs_fire     = fs_run_q & RX_BYTE_I & (fs_cnt_q == `HCES_FRAME_DELAY - 2'h1);
  wire ev_rsc   = auto_mode & REMOTE_READY_VALID_I & (REMOTE_READY_I != remote_ready_q);
  wire ev_pce   = auto_mode & (BAD_NR_I | SFRAME_INFO_I);
  wire ev_dpll_unsync_flag  = dpll_unsync & dpll_lock_q;
  wire ev_carrier_change_flag  = CARRIER_DETECT_I != cd_q;
  wire pool_hit = FRAME_FILL_I >= `HCES_POOL_BYTES;
  wire ev_rpf   = ~dma_mode & pool_hit & ~fill_hit_q & ~FRAME_END_I;
  wire ev_eop   = loop_mode & END_OF_POLL_I;
  wire ev_olp   = loop_mode & (((loop_q == `HCES_LS_WAIT_ON) & END_OF_POLL_I)
                  | ((loop_q == `HCES_LS_ACTIVE) & LEAVE_ACTIVE_I));
  wire ev_rdo   = ~loop_mode & FIFO_OVERRUN_I;
  wire ev_active_on_loop_flag  = loop_mode & pend_act_q & END_OF_POLL_I;
  // shared positions carry loop or non-loop events
  wire ev_b6    = loop_mode ? ev_olp : ev_rdo;

  wire ev_rfo   = FRAME_DISCARD_I;

  wire [7:0] ev_a = {1'b0, fs_fire, ev_rsc, ev_pce, ev_dpll_unsync_flag, ev_carrier_change_flag, ev_rfo, ev_rpf};
  wire [7:0] ev_b = {ev_eop, ev_b6, ev_active_on_loop_flag, 4'h0, TX_POOL_READY_I};

  // masked events are kept only with the visible option
  function [7:0] keep;
    input [7:0] ev;
    input [7:0] mask;
    input       v;
    begin
      keep = ev & (~mask | {8{v}});
    end
  endfunction

  assign RX_ABORT_O  = dpll_unsync;
  assign TX_HALT_O   = dpll_unsync & dpll_tx;
  assign OWN_TX_EN_O = loop_q == `HCES_LS_ACTIVE;
  // masked bits never reach the summary, even when visible
  assign EVENT_SUMMARY_O = {|(stat_a_q & ~mask_a_q), |(stat_b_q & ~mask_b_q)};
  assign INT_GROUP8_O = stat_b_q[`HCES_B_OLP] & ~mask_b_q[`HCES_B_OLP] & ~loop_mode;

  ////////////////////////////////////////////////////////////////////////////
  // status update shared by both registers
  function [7:0] stat_next;
    input [7:0] cur;
    input [7:0] clr;
    input [7:0] ev;
    begin
      // set wins over clear in the same cycle
      stat_next = (cur & ~clr) | ev;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus side: wait state, read data, control and masks
  always @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_done_q      <= 1'b0;
      ctrl_q         <= {`HCES_CTL_W{1'b0}};
      mask_a_q       <= `HCES_MASK_RST;
      mask_b_q       <= `HCES_MASK_RST;
      AVS_READDATA_O <= 32'h0;
    end
    else
    begin
      rd_done_q <= req & ~rd_done_q;
      if (wr_acc)
      begin
        case (AVS_ADDRESS_I)
          `HCES_ADDR_CTRL:   ctrl_q   <= AVS_WRITEDATA_I[`HCES_CTL_W-1:0];
          `HCES_ADDR_STAT_A: mask_a_q <= AVS_WRITEDATA_I[7:0];
          `HCES_ADDR_STAT_B: mask_b_q <= AVS_WRITEDATA_I[7:0];
          default:           ctrl_q   <= ctrl_q;
        endcase
      end
      if (rd_first)
      begin
        case (AVS_ADDRESS_I)
          `HCES_ADDR_STAT_A: AVS_READDATA_O <= {24'h0, stat_a_q};
          `HCES_ADDR_STAT_B: AVS_READDATA_O <= {24'h0, stat_b_q};
          `HCES_ADDR_CTRL:   AVS_READDATA_O <= {26'h0, ctrl_q};
          `HCES_ADDR_STATE:  AVS_READDATA_O <= {28'h0, loop_q, remote_ready_q, dpll_lock_q};
          `HCES_ADDR_LINE:   AVS_READDATA_O <= {31'h0, cd_q};
          `HCES_ADDR_RXINFO: AVS_READDATA_O <= {12'h0, stat_low_q, addr_low_q, ctl_field_q};
          default:           AVS_READDATA_O <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status registers
  always @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_a_q <= `HCES_STAT_RST;
      stat_b_q <= `HCES_STAT_RST;
    end
    else
    begin
      stat_a_q <= stat_next(stat_a_q, clr_a, keep(ev_a, mask_a_q, masked_visible_option));
      stat_b_q <= stat_next(stat_b_q, clr_b, keep(ev_b, mask_b_q, masked_visible_option));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame-start byte counter and header capture
  always @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fs_cnt_q    <= 2'h0;
      fs_run_q    <= 1'b0;
      ctl_field_q <= 8'h00;
      addr_low_q  <= 8'h00;
      stat_low_q  <= 4'h0;
    end
    else
    begin
      // frame-start counts two received bytes, then fires
      if (FRAME_START_I & ~RX_ABORT_O)
      begin
        fs_run_q <= 1'b1;
        fs_cnt_q <= 2'h0;
      end
      else if (fs_run_q & RX_BYTE_I)
      begin
        fs_cnt_q <= fs_cnt_q + 2'h1;
        if (fs_fire)
          fs_run_q <= 1'b0;
      end
      if (RX_ABORT_O)
        fs_run_q <= 1'b0;
      // capture header with the flag so software sees it settled
      if (fs_fire)
      begin
        ctl_field_q <= RX_CONTROL_FIELD_I;
        addr_low_q  <= RX_ADDRESS_LOW_I;
        stat_low_q  <= RX_STATUS_LOW_I;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line and remote state samples used for edge detection
  always @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remote_ready_q <= 1'b0;
      dpll_lock_q    <= 1'b0;
      cd_q           <= 1'b0;
      fill_hit_q     <= 1'b0;
    end
    else
    begin
      if (auto_mode & REMOTE_READY_VALID_I)
        remote_ready_q <= REMOTE_READY_I;
      dpll_lock_q <= ~dpll_unsync;
      cd_q        <= CARRIER_DETECT_I;
      // one pool-full event each time the fill reaches the pool size; rearmed when the fill drops or the frame ends
      if (FRAME_END_I | ~pool_hit)
        fill_hit_q <= 1'b0;
      else
        fill_hit_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop state machine and bit repeater
  reg rxd_dly_q;

  always @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loop_q     <= `HCES_LS_OFF;
      pend_act_q <= 1'b0;
    end
    else
    begin
      if (!loop_mode)
      begin
        loop_q     <= `HCES_LS_OFF;
        pend_act_q <= 1'b0;
      end
      else
      begin
        if (GO_ACTIVE_I & (loop_q == `HCES_LS_ON))
          pend_act_q <= 1'b1;
        else if (ev_active_on_loop_flag)
          pend_act_q <= 1'b0;
        case (loop_q)
          `HCES_LS_OFF:     if (GO_ON_LOOP_I) loop_q <= `HCES_LS_WAIT_ON;
          `HCES_LS_WAIT_ON: if (END_OF_POLL_I) loop_q <= `HCES_LS_ON;
          `HCES_LS_ON:      if (ev_active_on_loop_flag) loop_q <= `HCES_LS_ACTIVE;
          `HCES_LS_ACTIVE:  if (LEAVE_ACTIVE_I) loop_q <= `HCES_LS_ON;
          default:          loop_q <= `HCES_LS_OFF;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit repeater; idle line level is high
  always @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_dly_q <= 1'b1;
      TXD_O     <= 1'b1;
    end
    else if (BIT_STROBE_I)
    begin
      rxd_dly_q <= RXD_I;
      if (loop_q == `HCES_LS_ON)
        TXD_O <= rxd_dly_q;
      else
        TXD_O <= OWN_TXD_I;
    end
  end

endmodule

// File: test/hces_props.sv
`timescale 1ns/1ns
`include "hces_map.vh"
module hces_props
(
  // watched ports
  input wire logic        CORE_CLK_I, RST_N_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O,
  input wire logic [9:0]  AVS_ADDRESS_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic        CARRIER_DETECT_I, BAD_NR_I, DPLL_LOCK_I, END_OF_POLL_I,
  input wire logic        FIFO_OVERRUN_I, TX_POOL_READY_I, LEAVE_ACTIVE_I,
  input wire logic        RX_ABORT_O, TX_HALT_O, INT_GROUP8_O,
  input wire logic [1:0]  EVENT_SUMMARY_O
);
  logic [7:0] mask_a_q;
  logic [7:0] ctl_q;
  wire        wr_acc = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  // shadow of the host writes so that the properties know mask and mode
  always @(posedge CORE_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      mask_a_q <= `HCES_MASK_RST;
      ctl_q    <= 8'h00;
    end
    else if (wr_acc && AVS_ADDRESS_I == `HCES_ADDR_STAT_A)
      mask_a_q <= AVS_WRITEDATA_I[7:0];
    else if (wr_acc && AVS_ADDRESS_I == `HCES_ADDR_CTRL)
      ctl_q <= AVS_WRITEDATA_I[7:0];
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd_b;
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `HCES_ADDR_STAT_B;
  endsequence
  sequence s_b_quiet;
    !(END_OF_POLL_I || FIFO_OVERRUN_I || TX_POOL_READY_I || LEAVE_ACTIVE_I);
  endsequence
  property p_clr_b;
    s_rd_b ##0 s_b_quiet |=> !EVENT_SUMMARY_O[0];
  endproperty
  property p_wait;
    $rose(AVS_READ_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endproperty
  property p_abort;
    RX_ABORT_O == (ctl_q[`HCES_CTL_DPLL_RX] && !DPLL_LOCK_I);
  endproperty
  property p_halt;
    TX_HALT_O == (RX_ABORT_O && ctl_q[`HCES_CTL_DPLL_TX]);
  endproperty
  property p_grp8;
    INT_GROUP8_O |-> EVENT_SUMMARY_O[0] && !ctl_q[`HCES_CTL_LOOP];
  endproperty
  property p_mask;
    mask_a_q == 8'hFF && $past(mask_a_q) == 8'hFF |-> !EVENT_SUMMARY_O[1];
  endproperty
  property p_cd;
    $changed(CARRIER_DETECT_I) && !mask_a_q[`HCES_A_CARRIER_CHANGE_FLAG] |-> ##[1:3] EVENT_SUMMARY_O[1];
  endproperty
  property p_pce;
    BAD_NR_I && ctl_q[`HCES_CTL_AUTO] && !mask_a_q[`HCES_A_PCE] |-> ##[1:2] EVENT_SUMMARY_O[1];
  endproperty
  a_clr_b: assert property (p_clr_b) else $error("status b pending after read");
  a_wait: assert property (p_wait) else $error("waitrequest timing wrong");
  a_abort: assert property (p_abort) else $error("receiver abort wrong");
  a_halt: assert property (p_halt) else $error("transmit halt wrong");
  a_grp8: assert property (p_grp8) else $error("group 8 request wrong");
  a_mask: assert property (p_mask) else $error("masked event in summary");
  a_cd: assert property (p_cd) else $error("carrier change missed");
  a_pce: assert property (p_pce) else $error("protocol error missed");
endmodule
bind hces_top hces_props u_props (.CORE_CLK_I, .RST_N_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_WAITREQUEST_O, .AVS_ADDRESS_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .CARRIER_DETECT_I,
  .BAD_NR_I, .DPLL_LOCK_I, .END_OF_POLL_I, .FIFO_OVERRUN_I, .TX_POOL_READY_I, .LEAVE_ACTIVE_I,
  .RX_ABORT_O, .TX_HALT_O, .INT_GROUP8_O, .EVENT_SUMMARY_O);

// File: test/hces_remote.sv
`timescale 1ns/1ns
module hces_remote
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  output logic      strobe_o,
  output logic      rxd_o
);
  logic [1:0] cnt_q;
  logic [7:0] pat_q;
  // one bit every four clocks; strobe only while a frame runs
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      cnt_q    <= 2'h0;
      strobe_o <= 1'b0;
      rxd_o    <= 1'b1;
      pat_q    <= 8'hB4;
    end
    else
    begin
      cnt_q    <= cnt_q + 2'h1;
      strobe_o <= en_i && cnt_q == 2'h3;
      if (strobe_o)
        pat_q <= {pat_q[6:0], pat_q[7]};
      // idle line is pulled high between frames
      rxd_o <= en_i ? (strobe_o ? pat_q[7] : rxd_o) : 1'b1;
    end
endmodule

// File: test/tb.sv
`timescale 1ns/1ns
`include "hces_map.vh"
module tb;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, cd = 1'b0, lock = 1'b1;
  logic own = 1'b1, rem_en = 1'b0, r = 1'b1, rp;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] be = 4'hF;
  logic [13:0] pl = 14'h0;
  logic [5:0] fill = 6'h00;
  wire [31:0] rdq;
  wire [1:0] summ;
  wire wait_w, strobe, rxd, txd, own_en;
  int miscompares = 0, total_checks = 0, i;
  // rows: control value, event code, expected status a, expected status b
  logic [31:0] rows [0:10] = '{32'h01001000, 32'h00000000, 32'h01011000,
    32'h01052000, 32'h00020200, 32'h00030040,
    32'h02030000, 32'h00040001, 32'h00100400, 32'h00100400, 32'h18110800};
  initial forever #4 clk = ~clk;
  hces_remote u_rem (.clk_i(clk), .rst_n_i(rst_n), .en_i(rem_en), .strobe_o(strobe), .rxd_o(rxd));
  hces_top u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdq),
    .AVS_WAITREQUEST_O(wait_w), .FRAME_START_I(pl[6]), .RX_BYTE_I(pl[7]),
    .RX_CONTROL_FIELD_I(8'h5A), .RX_ADDRESS_LOW_I(8'hC3), .RX_STATUS_LOW_I(4'h9),
    .REMOTE_READY_I(1'b1), .REMOTE_READY_VALID_I(pl[5]), .BAD_NR_I(pl[0]), .SFRAME_INFO_I(pl[1]),
    .DPLL_LOCK_I(lock), .CARRIER_DETECT_I(cd), .FRAME_DISCARD_I(pl[2]), .FRAME_FILL_I(fill),
    .FRAME_END_I(pl[13]), .FIFO_OVERRUN_I(pl[3]), .END_OF_POLL_I(pl[8]), .TX_POOL_READY_I(pl[4]),
    .TX_POOL_VECTOR_I(pl[12]), .GO_ON_LOOP_I(pl[9]), .GO_ACTIVE_I(pl[10]),
    .LEAVE_ACTIVE_I(pl[11]), .BIT_STROBE_I(strobe), .RXD_I(rxd), .OWN_TXD_I(own), .TXD_O(txd),
    .RX_ABORT_O(), .TX_HALT_O(), .OWN_TX_EN_O(own_en), .EVENT_SUMMARY_O(summ), .INT_GROUP8_O());
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge; data taken there
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_w !== 1'b0 && n < 64);
    if (n >= 64) miscompares++;
    rdata = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task pulse(input int ev);
    @(posedge clk);
    if (ev == 16) cd <= !cd;
    else if (ev == 17) lock <= 1'b0;
    else pl <= 14'h1 << ev;
    @(posedge clk);
    pl <= 14'h0;
    lock <= 1'b1;
  endtask
  task bitw;
    do @(negedge clk); while (strobe !== 1'b1);
    rp = r;
    r = rxd;
    @(posedge clk);
    #1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(txd, 1);
    rdc(`HCES_ADDR_STAT_A, 0);
    rdc(`HCES_ADDR_STAT_B, `HCES_STAT_RST);
    rdc(10'h000, 0);
    @(posedge clk) be <= 4'h0;
    bus(1'b1, `HCES_ADDR_CTRL, 1);
    @(posedge clk) be <= 4'hF;
    rdc(`HCES_ADDR_CTRL, 0);
    bus(1'b1, `HCES_ADDR_STAT_A, 0);
    bus(1'b1, `HCES_ADDR_STAT_B, 0);
    for (i = 0; i < 11; i++)
    begin
      bus(1'b1, `HCES_ADDR_CTRL, rows[i][31:24]);
      pulse(rows[i][23:16]);
      rdc(`HCES_ADDR_STAT_A, rows[i][15:8]);
      rdc(`HCES_ADDR_STAT_B, rows[i][7:0]);
    end
    rdc(`HCES_ADDR_STATE, 32'h3);
    rdc(`HCES_ADDR_LINE, {31'h0, cd});
    pulse(6);
    pulse(7);
    rdc(`HCES_ADDR_STAT_A, 0);
    pulse(7);
    rdc(`HCES_ADDR_STAT_A, 32'h40);
    rdc(`HCES_ADDR_RXINFO, 32'h9C35A);
    bus(1'b1, `HCES_ADDR_CTRL, 0);
    @(posedge clk) fill <= `HCES_POOL_BYTES;
    rdc(`HCES_ADDR_STAT_A, 32'h1);
    @(posedge clk) fill <= 6'h00;
    pulse(13);
    bus(1'b1, `HCES_ADDR_CTRL, 4);
    @(posedge clk) fill <= `HCES_POOL_BYTES;
    rdc(`HCES_ADDR_STAT_A, 0);
    bus(1'b1, `HCES_ADDR_CTRL, 2);
    pulse(9);
    rdc(`HCES_ADDR_STAT_B, 0);
    pulse(8);
    rdc(`HCES_ADDR_STAT_B, 32'hC0);
    @(posedge clk) rem_en <= 1'b1;
    repeat (6) begin bitw; chk(txd, rp); end
    pulse(10);
    rdc(`HCES_ADDR_STAT_B, 0);
    pulse(8);
    rdc(`HCES_ADDR_STAT_B, 32'hA0);
    chk(own_en, 1);
    @(posedge clk) own <= 1'b0;
    bitw;
    chk(txd, 0);
    pulse(11);
    rdc(`HCES_ADDR_STAT_B, 32'h40);
    @(posedge clk) rem_en <= 1'b0;
    pulse(4);
    pulse(12);
    rdc(`HCES_ADDR_STAT_B, 0);
    results;
  end
endmodule
